// file: verif/crl_load_unit_assertions.sv
// Assertion checker for the control register load unit
`timescale 1ns/1ps
`include "crl_defines.svh"

module crl_load_unit_checker (
    // Clock and reset
    input wire logic                  clk_sys,
    input wire logic                  rst_n,
    // Bus slave side
    input wire logic                  hsel,
    input wire logic [31:0]           haddr,
    input wire logic [1:0]            htrans,
    input wire logic                  hwrite,
    input wire logic [2:0]            hsize,
    input wire logic [31:0]           hwdata,
    input wire logic                  hready,
    input wire logic                  hreadyout,
    input wire logic [31:0]           hrdata,
    input wire logic                  hresp,
    // Sequencer side
    input wire logic                  instr_valid,
    input wire crl_pkg::crl_instr_s   instr,
    input wire logic                  instr_ready,
    input wire logic                  instr_done,
    input wire logic [`CRL_DEST_W-1:0] done_dest,
    // Planes and edge register
    input wire logic [`CRL_ES-1:0][`CRL_ES-1:0] acc_plane,
    input wire logic [`CRL_ES-1:0][`CRL_ES-1:0] act_plane,
    input wire logic [`CRL_ES-1:0]    edge_reg
);
    // Reference row reductions of both planes
    logic [`CRL_ES-1:0] acc_and, act_and;
    // Decoded kind of the presented instruction
    wire is_acc  = instr.op == crl_pkg::OP_ACCUMULATOR_COLUMN_REDUCE;
    wire is_act  = instr.op == crl_pkg::OP_INVERTED_ACTIVITY_REDUCE;
    wire to_edge = instr.dest == `CRL_DEST_EDGE;
    wire rd_req  = hsel && htrans[1] && hready && !hwrite;

    // Per-row AND across the columns
    always_comb
    begin
        for (int r = 0; r < `CRL_ES; r++)
        begin
            acc_and[r] = &acc_plane[r];
            act_and[r] = &(~act_plane[r]);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Steps of an executed instruction
    sequence s_issue;
        instr_valid && instr_ready;
    endsequence
    sequence s_edge_write;
        s_issue ##0 ((is_acc || is_act) && to_edge);
    endsequence

    a_done_after_issue: assert property (
        s_issue |=> instr_done && done_dest == $past(instr.dest))
        else $error("done pulse missing after issue");
    a_no_stray_done: assert property (
        !(instr_valid && instr_ready) |=> !instr_done)
        else $error("done without an issue");
    a_acc_edge_value: assert property (
        s_edge_write ##0 is_acc |=> edge_reg == $past(acc_and))
        else $error("edge register differs from accumulator reduce");
    a_act_edge_value: assert property (
        s_edge_write ##0 is_act |=> edge_reg == $past(act_and))
        else $error("edge register differs from activity reduce");
    a_edge_kept: assert property (
        !(instr_valid && instr_ready && (is_acc || is_act) && to_edge)
        |=> $stable(edge_reg))
        else $error("edge register changed without a reduce to it");
    a_ready_after_reset: assert property (
        $rose(rst_n) |-> instr_ready)
        else $error("not ready after reset");
    a_zero_wait_okay: assert property (
        hsel && htrans[1] && hready
        |=> hreadyout && hresp == `CRL_HRESP_OKAY)
        else $error("bus transfer stalled or refused");
    a_rdata_holds: assert property (
        !rd_req [*2] |-> $stable(hrdata))
        else $error("read data changed without a read");
endmodule : crl_load_unit_checker

bind crl_load_unit crl_load_unit_checker crl_load_unit_checker_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .instr_done(instr_done),
    .done_dest(done_dest), .acc_plane(acc_plane),
    .act_plane(act_plane), .edge_reg(edge_reg)
);

// file: verif/crl_load_unit_bench.sv
// Self-checking bench for the control register load unit
`timescale 1ns/1ps
`include "crl_defines.svh"

module crl_load_unit_bench;
    // One table row: instruction and expected register value
    typedef struct packed {
        crl_pkg::crl_instr_s ins;
        logic [31:0]         exp;
    } crl_row_s;

    logic                 clk_sys = 1'b0;  // System clock
    logic                 rst_n = 1'b0;    // Reset, active low
    logic                 hsel = 1'b0;     // Bus select
    logic [31:0]          haddr = '0;      // Bus address
    logic [1:0]           htrans = '0;     // Bus transfer type
    logic                 hwrite = 1'b0;   // Bus direction
    logic [31:0]          hwdata = '0;     // Bus write data
    wire  logic           hready;          // Bus ready, our own slave
    logic                 hreadyout;       // Slave ready
    logic [31:0]          hrdata;          // Slave read data
    logic                 hresp;           // Slave response
    logic                 instr_valid = 1'b0; // Instruction present
    crl_pkg::crl_instr_s  instr = '0;      // Instruction fields
    logic                 instr_ready;     // Unit accepts
    logic                 instr_done;      // Completion pulse
    logic [4:0]           done_dest;       // Completed destination
    logic                 mode = 1'b0;     // Plane pattern select
    logic [63:0]          edge_reg;        // Edge register
    logic [`CRL_ES-1:0][`CRL_ES-1:0] acc_plane, act_plane;
    crl_row_s             rows[$];         // Ordinary cases
    int                   fails = 0;       // Mismatches
    int                   n_compared = 0;  // Comparisons made
    int                   cycles = 0;      // Run length guard

    assign hready = hreadyout;
    always #5 clk_sys = ~clk_sys;

    crl_plane_model crl_plane_model_inst (.mode(mode),
        .acc_plane(acc_plane), .act_plane(act_plane));
    crl_load_unit crl_load_unit_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .instr_valid(instr_valid), .instr(instr),
        .instr_ready(instr_ready), .instr_done(instr_done),
        .done_dest(done_dest), .acc_plane(acc_plane),
        .act_plane(act_plane), .edge_reg(edge_reg));

    // Verdict and end of run
    task give_verdict;
        if (fails == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    // Hang guard
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            fails++;
            give_verdict;
        end
    end

    // Compare and count
    task check(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Build an instruction: op code, dest, {mod_en,mod}, address,
    // literal and {count,geom,dir}
    function automatic crl_pkg::crl_instr_s mk(input logic [3:0] op,
        input logic [4:0] d, input logic [4:0] m, input logic [31:0] a,
        input logic [15:0] l, input logic [11:0] g);
        mk.op      = crl_pkg::crl_op_e'(op);
        mk.dest    = d;
        {mk.mod_en, mk.modifier_selector} = m;
        mk.addr    = a;
        mk.literal = l;
        mk.count   = g[11:4];
        mk.geom    = crl_pkg::crl_geom_e'(g[3:2]);
        mk.dir     = crl_pkg::crl_dir_e'(g[1:0]);
    endfunction : mk

    // Append one table row
    task add(input logic [3:0] op, input logic [4:0] d, input logic [4:0] m,
        input logic [31:0] a, input logic [15:0] l, input logic [11:0] g,
        input logic [31:0] e);
        rows.push_back('{mk(op, d, m, a, l, g), e});
    endtask : add

    // One bus transfer, waiting on ready in both phases
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        r = hrdata;
    endtask : ahb

    // Bus read compared with an expectation
    task rdchk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        check({32'h0, r}, {32'h0, e});
    endtask : rdchk

    // Issue one instruction and check the completion pulse
    task issue(input crl_pkg::crl_instr_s x, input logic e);
        @(posedge clk_sys);
        instr_valid <= 1'b1;
        instr       <= x;
        @(posedge clk_sys);
        instr_valid <= 1'b0;
        #1;
        check({63'h0, instr_done}, {63'h0, e});
        if (e)
            check({59'h0, done_dest}, {59'h0, x.dest});
    endtask : issue

    // Main sequence
    initial
    begin
        logic [31:0] r;
        add(4'h3, 5'h03, 5'h00, 32'h0, 16'h001E, 12'h0, 32'h1E);
        add(4'h4, 5'h02, 5'h00, 32'h0, 16'h0021, 12'h0, 32'hFFFFFFDE);
        add(4'h1, 5'h01, 5'h00, 32'h0, 16'h0, 12'h030, 32'h300);
        add(4'h1, 5'h01, 5'h00, '1, 16'hFFFF, 12'h005, 32'h5);
        add(4'h1, 5'h01, 5'h00, 32'h0, 16'h0, 12'h00A, 32'hA);
        add(4'h1, 5'h01, 5'h00, 32'h0, 16'h0, 12'h00F, 32'hF);
        add(4'h0, 5'h04, 5'h00, 32'h3821, 16'h0, 12'h0, 32'h3821);
        add(4'h0, 5'h05, 5'h14, 32'h7FF, 16'h0, 12'h0, 32'h4010);
        add(4'h0, 5'h06, 5'h05, 32'h7FF, 16'h0, 12'h0, 32'h7FF);
        add(4'h7, 5'h07, 5'h03, 32'h0, 16'h0, 12'h0, 32'h1E);
        add(4'h8, 5'h08, 5'h03, 32'h0, 16'h0, 12'h0, 32'hFFFFFFE1);
        add(4'h8, 5'h08, 5'h08, 32'h0, 16'h0, 12'h0, 32'h1E);
        add(4'h2, 5'h03, 5'h00, 32'h0, 16'h0, 12'h0, 32'h0);
        add(4'h5, 5'h09, 5'h00, 32'h0, 16'h0, 12'h0, 32'h55555555);
        add(4'h6, 5'h0A, 5'h00, 32'h0, 16'h0, 12'h0, 32'hF);
        add(4'h4, 5'h0F, 5'h00, 32'h0, 16'hFFFF, 12'h0, 32'hFFFF0000);
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (rows[i])
        begin
            issue(rows[i].ins, 1'b1);
            rdchk(32'h40 + 4 * rows[i].ins.dest, rows[i].exp);
        end
        // Full-width reduces into the edge register
        mode <= 1'b1;
        issue(mk(4'h5, 5'h10, 5'h00, 32'h0, 16'h0, 12'h0), 1'b1);
        check(edge_reg, '1);
        rdchk(`CRL_OFS_EDGE_HI, 32'hFFFFFFFF);
        mode <= 1'b0;
        issue(mk(4'h6, 5'h10, 5'h00, 32'h0, 16'h0, 12'h0), 1'b1);
        rdchk(`CRL_OFS_EDGE_LO, 32'hF);
        issue(mk(4'h5, 5'h10, 5'h00, 32'h0, 16'h0, 12'h0), 1'b1);
        check(edge_reg, {32{2'b01}});
        // Non-reduce to edge code and an unused code write nothing
        issue(mk(4'h3, 5'h10, 5'h00, 32'h0, 16'h1234, 12'h0), 1'b1);
        issue(mk(4'h3, 5'h11, 5'h00, 32'h0, 16'h1234, 12'h0), 1'b1);
        check(edge_reg, {32{2'b01}});
        rdchk(32'h44, 32'hF);
        // Back to back: each step sees the previous result
        @(posedge clk_sys);
        instr_valid <= 1'b1;
        instr <= mk(4'h3, 5'h0B, 5'h00, 32'h0, 16'h00A5, 12'h0);
        @(posedge clk_sys);
        instr <= mk(4'h7, 5'h0C, 5'h0B, 32'h0, 16'h0, 12'h0);
        @(posedge clk_sys);
        instr <= mk(4'h8, 5'h0D, 5'h0C, 32'h0, 16'h0, 12'h0);
        @(posedge clk_sys);
        instr_valid <= 1'b0;
        rdchk(32'h40 + 4 * 12, 32'hA5);
        rdchk(32'h40 + 4 * 13, 32'hFFFFFF5A);
        // Disabled unit ignores instructions
        ahb(1'b1, `CRL_OFS_CTRL, 32'h0, r);
        issue(mk(4'h3, 5'h0E, 5'h00, 32'h0, 16'h0077, 12'h0), 1'b0);
        rdchk(32'h40 + 4 * 14, 32'h0);
        ahb(1'b1, `CRL_OFS_CTRL, 32'h1, r);
        rdchk(`CRL_OFS_STATUS, 32'h000D0018);
        // Unmapped read and read-only window write
        rdchk(32'h20, 32'h0);
        ahb(1'b1, 32'h48, 32'h0, r);
        rdchk(32'h48, 32'hFFFFFFDE);
        // Second reset in mid-run
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1;
        check(edge_reg, 64'h0);
        rdchk(`CRL_OFS_CTRL, 32'h1);
        rdchk(32'h48, 32'h0);
        give_verdict;
    end
endmodule : crl_load_unit_bench

// file: verif/crl_plane_model.sv
// Processor-array plane model feeding the reduce operations
`timescale 1ns/1ps
`include "crl_defines.svh"

module crl_plane_model (
    // Pattern select: 0 mixed rows, 1 all ones
    input  wire logic                         mode,
    // Accumulator and activity planes, row then column
    output logic [`CRL_ES-1:0][`CRL_ES-1:0]   acc_plane,
    output logic [`CRL_ES-1:0][`CRL_ES-1:0]   act_plane
);
    // In mode 0, odd accumulator rows lose one column; low activity rows are clear
    always_comb
    begin
        for (int r = 0; r < `CRL_ES; r++)
        begin
            acc_plane[r] = (mode || !r[0]) ? '1 : ~(64'h1 << r);
            act_plane[r] = mode ? '1 : ((r < 4) ? '0 : 64'h1);
        end
    end
endmodule : crl_plane_model

// file: verilog/crl_addr_calc.sv
// Effective row address adder with row-to-plane carry
`timescale 1ns/1ps
`include "crl_defines.svh"

module crl_addr_calc (
    // Address fields of the instruction
    input  wire crl_pkg::crl_addr_s  base,
    // Modifier register contents and its enable
    input  wire logic [`CRL_CR_W-1:0] mod_val,
    input  wire logic                 mod_en,
    // Effective address
    output crl_pkg::crl_addr_s        eff
);

    crl_pkg::crl_addr_s       offs;      // Offset, zero when no modifier
    logic [`CRL_ROW_W:0]      row_sum;   // Row sum with carry bit
    logic                     row_carry; // Carry into the plane sum

    // No modifier selected adds nothing
    assign offs = mod_en ? crl_pkg::crl_addr_s'(mod_val)
                         : crl_pkg::crl_addr_s'(`CRL_CR_RESET);

    // Row index sum, carry kept for the plane
    assign row_sum   = {1'b0, base.row} + {1'b0, offs.row};
    assign row_carry = row_sum[`CRL_ROW_W];

    // Plane sum takes the row carry in
    assign eff.plane = base.plane + offs.plane
                     + {{(`CRL_PLANE_W-1){1'b0}}, row_carry};
    assign eff.row   = row_sum[`CRL_ROW_W-1:0];
    assign eff.word  = base.word + offs.word;

endmodule : crl_addr_calc

// file: verilog/crl_and_reduce.sv
// Per-row AND across all columns of one bit plane
`timescale 1ns/1ps
`include "crl_defines.svh"

module crl_and_reduce #(
    parameter bit INVERT = 1'b0   // Complement the plane before reducing
) (
    // Plane, indexed row then column
    input  wire logic [`CRL_ES-1:0][`CRL_ES-1:0] plane,
    // One result bit per row
    output logic      [`CRL_ES-1:0]              result
);

    // One AND tree per row position
    for (genvar r = 0; r < `CRL_ES; r++)
    begin : g_row
        assign result[r] = INVERT ? &(~plane[r]) : &plane[r];
    end

endmodule : crl_and_reduce

// file: verilog/crl_defines.svh
// Constants for the control register load unit
`ifndef CRL_DEFINES_SVH
`define CRL_DEFINES_SVH

// Edge size: rows and columns of one bit plane
`define CRL_ES            64
// Number of control registers and their width
`define CRL_CR_NUM        16
`define CRL_CR_IDX_W      4
`define CRL_CR_W          32
`define CRL_CR_RESET      32'h0000_0000
// Literal field width
`define CRL_LIT_W         16
// Address fields of a control register: word, row index, plane address
`define CRL_WORD_W        4
`define CRL_ROW_W         6
`define CRL_PLANE_W       22
// Shift descriptor fields
`define CRL_COUNT_W       8
`define CRL_SHIFT_ZMID_W  4
`define CRL_SHIFT_ZHI_W   16
// Destination selector: width and the code that names the edge register
`define CRL_DEST_W        5
`define CRL_DEST_EDGE     5'h10
// Status counter width
`define CRL_OPCNT_W       16

// Bus register byte offsets
`define CRL_OFS_CTRL      32'h0000_0000
`define CRL_OFS_STATUS    32'h0000_0004
`define CRL_OFS_EDGE_LO   32'h0000_0008
`define CRL_OFS_EDGE_HI   32'h0000_000C
`define CRL_OFS_CR_BASE   32'h0000_0040
// Word index bits of the control register window
`define CRL_CR_WIN_LSB    2
`define CRL_CR_WIN_MSB    5
// Control register: enable bit and its reset value
`define CRL_CTRL_EN_BIT   0
`define CRL_CTRL_RESET    1'b1
// Status register field positions
`define CRL_STAT_DEST_LSB 16
`define CRL_STAT_EDGE_BIT 24
// Bus encodings
`define CRL_HTRANS_NONSEQ_BIT 1
`define CRL_HRESP_OKAY    1'b0

`endif

// file: verilog/crl_load_unit.sv
// Control register load unit: datapath, register file and bus slave
`timescale 1ns/1ps
`include "crl_defines.svh"

module crl_load_unit (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic [31:0]                hrdata,
    output logic                       hresp,
    // Instruction sequencer
    input  wire logic                  instr_valid,
    input  wire crl_pkg::crl_instr_s   instr,
    output logic                       instr_ready,
    output logic                       instr_done,
    output logic [`CRL_DEST_W-1:0]     done_dest,
    // Processor array planes and edge register
    input  wire logic [`CRL_ES-1:0][`CRL_ES-1:0] acc_plane,
    input  wire logic [`CRL_ES-1:0][`CRL_ES-1:0] act_plane,
    output logic [`CRL_ES-1:0]         edge_reg
);

    // Control register file
    logic [`CRL_CR_W-1:0]      cr [`CRL_CR_NUM];
    // Software enable of instruction execution
    logic                      exec_en;
    // Status: executed operation count, last destination, edge flag
    logic [`CRL_OPCNT_W-1:0]   op_count;
    logic [`CRL_DEST_W-1:0]    last_dest;
    logic                      last_edge;
    // Captured bus address phase
    logic                      ap_write;
    logic [31:0]               ap_addr;

    // Datapath wires
    logic [`CRL_CR_W-1:0]      sel_val;     // Modifier or source register
    crl_pkg::crl_addr_s        eff_addr;    // Effective row address
    crl_pkg::crl_shift_s       shift_desc;  // Built shift descriptor
    logic [`CRL_CR_W-1:0]      lit_ext;     // Zero-extended literal
    logic [`CRL_ES-1:0]        acc_and;     // Accumulator reduction
    logic [`CRL_ES-1:0]        act_and;     // Activity reduction
    logic [`CRL_ES-1:0]        reduce_val;  // Reduction of this op
    logic [`CRL_CR_W-1:0]      next_cr;     // Value for a control reg
    logic                      is_reduce;   // Op may target the edge
    logic                      dest_edge;   // Destination is the edge
    logic                      dest_cr;     // Destination is a control reg
    logic                      issue;       // Instruction executes now
    logic                      cr_we;       // Control register write
    logic                      edge_we;     // Edge register write

    // Bus decode wires
    logic                      ap_take;     // Address phase accepted
    logic                      rd_take;     // Read accepted
    logic                      wr_ctrl;     // Data phase write to control
    logic                      hit_cr;      // Address falls in CR window
    logic [`CRL_CR_IDX_W-1:0]  win_idx;     // Index within CR window
    logic [31:0]               rd_mux;      // Read data selection

    // Modifier field also serves as copy source
    assign sel_val = cr[instr.modifier_selector];

    // Effective address adder
    crl_addr_calc u_addr_calc (
        .base    (instr.addr),
        .mod_val (sel_val),
        .mod_en  (instr.mod_en),
        .eff     (eff_addr)
    );

    // Column AND of the accumulator plane
    crl_and_reduce #(
        .INVERT (1'b0)
    ) u_acc_reduce (
        .plane  (acc_plane),
        .result (acc_and)
    );

    // Column AND of the complemented activity plane
    crl_and_reduce #(
        .INVERT (1'b1)
    ) u_act_reduce (
        .plane  (act_plane),
        .result (act_and)
    );

    // Shift descriptor: instruction fields, all other bits zero
    assign shift_desc.zero_hi  = '0;
    assign shift_desc.zero_mid = '0;
    assign shift_desc.count    = instr.count;
    assign shift_desc.geom     = instr.geom;
    assign shift_desc.dir      = instr.dir;

    // Literal widened with leading zeros; sign is already encoded
    assign lit_ext = `CRL_CR_W'(instr.literal);

    // Reduction of the current operation
    assign is_reduce =
        (instr.op == crl_pkg::OP_ACCUMULATOR_COLUMN_REDUCE) ||
        (instr.op == crl_pkg::OP_INVERTED_ACTIVITY_REDUCE);
    assign reduce_val =
        (instr.op == crl_pkg::OP_INVERTED_ACTIVITY_REDUCE) ? act_and
                                                           : acc_and;

    // Value written into a control register for each operation
    always_comb
    begin
        next_cr = `CRL_CR_RESET;
        unique case (instr.op)
            // Effective plane, row and word fields
            crl_pkg::OP_LOAD_ROW_ADDRESS:
                next_cr = eff_addr;
            // Direction, geometry and count
            crl_pkg::OP_LOAD_SHIFT_DESCRIPTOR:
                next_cr = shift_desc;
            // Every bit zero
            crl_pkg::OP_CLEAR_REGISTER:
                next_cr = `CRL_CR_RESET;
            // Zero-extended literal
            crl_pkg::OP_LOAD_SHORT_LITERAL:
                next_cr = lit_ext;
            // Complemented zero-extended literal
            crl_pkg::OP_LOAD_INVERTED_SHORT_LITERAL:
                next_cr = ~lit_ext;
            // Low 32 bits of the reduction
            crl_pkg::OP_ACCUMULATOR_COLUMN_REDUCE,
            crl_pkg::OP_INVERTED_ACTIVITY_REDUCE:
                next_cr = reduce_val[`CRL_CR_W-1:0];
            // Plain copy of the source register
            crl_pkg::OP_REGISTER_COPY:
                next_cr = sel_val;
            // Complement of source; same index inverts in place
            crl_pkg::OP_REGISTER_INVERTED_COPY:
                next_cr = ~sel_val;
            // Unused opcodes complete and write zero to a control register destination
            default:
                next_cr = `CRL_CR_RESET;
        endcase
    end

    // Destination decode: edge code or one of the control registers
    assign dest_edge = (instr.dest == `CRL_DEST_EDGE);
    assign dest_cr   = ~instr.dest[`CRL_DEST_W-1];

    // Only a valid instruction while enabled may write
    assign issue   = instr_valid & exec_en;
    assign cr_we   = issue & dest_cr;
    // Edge register written only by the reductions
    assign edge_we = issue & dest_edge & is_reduce;

    // Control register file, one writer per entry
    for (genvar i = 0; i < `CRL_CR_NUM; i++)
    begin : g_cr
        // Entry loads when it is the selected destination
        always_ff @(posedge clk_sys or negedge rst_n)
        begin
            if (!rst_n)
                cr[i] <= `CRL_CR_RESET;
            else if (cr_we && instr.dest[`CRL_CR_IDX_W-1:0] == i)
                cr[i] <= next_cr;
        end
    end

    // Edge register takes the whole edge-size reduction
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            edge_reg <= '0;
        else if (edge_we)
            edge_reg <= reduce_val;
    end

    // Completion pulse and destination, one cycle after issue
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            instr_done <= 1'b0;
            done_dest  <= '0;
        end
        else
        begin
            instr_done <= issue;
            done_dest  <= instr.dest;
        end
    end

    // Status counters follow the executed operations
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            op_count  <= '0;
            last_dest <= '0;
            last_edge <= 1'b0;
        end
        else if (issue)
        begin
            op_count  <= op_count + 1'b1;
            last_dest <= instr.dest;
            last_edge <= edge_we;
        end
    end

    // Bus address phase and read acceptance
    assign ap_take = hsel & hready & htrans[`CRL_HTRANS_NONSEQ_BIT];
    assign rd_take = ap_take & ~hwrite;
    // Data phase write to the control register
    assign wr_ctrl = ap_write & (ap_addr == `CRL_OFS_CTRL);

    // Control register window decode
    assign hit_cr  = ({haddr[31:`CRL_CR_WIN_MSB+1],
                       {(`CRL_CR_WIN_MSB+1){1'b0}}} == `CRL_OFS_CR_BASE);
    assign win_idx = haddr[`CRL_CR_WIN_MSB:`CRL_CR_WIN_LSB];

    // Read data selection; unmapped addresses read zero
    assign rd_mux =
        hit_cr                         ? cr[win_idx] :
        (haddr == `CRL_OFS_CTRL)       ? {31'h0000_0000, exec_en} :
        (haddr == `CRL_OFS_STATUS)     ? {7'h00, last_edge,
                                          3'h0, last_dest, op_count} :
        (haddr == `CRL_OFS_EDGE_LO)    ? edge_reg[`CRL_CR_W-1:0] :
        (haddr == `CRL_OFS_EDGE_HI)    ? edge_reg[`CRL_ES-1:`CRL_CR_W] :
                                         32'h0000_0000;

    // Capture write address phases for the following data phase
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ap_write <= 1'b0;
            ap_addr  <= '0;
        end
        else if (hready)
        begin
            ap_write <= ap_take & hwrite;
            ap_addr  <= haddr;
        end
    end

    // Read data registered at the address phase edge
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            hrdata <= '0;
        else if (rd_take)
            hrdata <= rd_mux;
    end

    // Enable bit; also drives the ready to the sequencer
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            exec_en     <= `CRL_CTRL_RESET;
            instr_ready <= `CRL_CTRL_RESET;
        end
        else if (wr_ctrl)
        begin
            exec_en     <= hwdata[`CRL_CTRL_EN_BIT];
            instr_ready <= hwdata[`CRL_CTRL_EN_BIT];
        end
    end

    // Zero wait states and always OKAY
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hreadyout <= 1'b1;
            hresp     <= `CRL_HRESP_OKAY;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= `CRL_HRESP_OKAY;
        end
    end

endmodule : crl_load_unit

// file: verilog/crl_pkg.sv
// Types shared by the control register load unit
`include "crl_defines.svh"

package crl_pkg;

    // Operations of the register load group
    typedef enum logic [3:0] {
        OP_LOAD_ROW_ADDRESS,
        OP_LOAD_SHIFT_DESCRIPTOR,
        OP_CLEAR_REGISTER,
        OP_LOAD_SHORT_LITERAL,
        OP_LOAD_INVERTED_SHORT_LITERAL,
        OP_ACCUMULATOR_COLUMN_REDUCE,
        OP_INVERTED_ACTIVITY_REDUCE,
        OP_REGISTER_COPY,
        OP_REGISTER_INVERTED_COPY
    } crl_op_e;

    // Shift direction
    typedef enum logic [1:0] {
        DIR_NORTH,
        DIR_EAST,
        DIR_SOUTH,
        DIR_WEST
    } crl_dir_e;

    // Shift geometry
    typedef enum logic [1:0] {
        GEOM_PLANAR,
        GEOM_CYCLIC,
        GEOM_PLANAR_NS_CYCLIC_EW,
        GEOM_CYCLIC_NS_PLANAR_EW
    } crl_geom_e;

    // Row address layout of a control register
    typedef struct packed {
        logic [`CRL_PLANE_W-1:0] plane;
        logic [`CRL_ROW_W-1:0]   row;
        logic [`CRL_WORD_W-1:0]  word;
    } crl_addr_s;

    // Shift descriptor layout of a control register
    typedef struct packed {
        logic [`CRL_SHIFT_ZHI_W-1:0]  zero_hi;
        logic [`CRL_COUNT_W-1:0]      count;
        logic [`CRL_SHIFT_ZMID_W-1:0] zero_mid;
        crl_geom_e                    geom;
        crl_dir_e                     dir;
    } crl_shift_s;

    // Instruction as presented by the sequencer
    typedef struct packed {
        crl_op_e                   op;
        logic [`CRL_DEST_W-1:0]    dest;
        logic                      mod_en;
        logic [`CRL_CR_IDX_W-1:0]  modifier_selector;
        crl_addr_s                 addr;
        logic [`CRL_LIT_W-1:0]     literal;
        crl_dir_e                  dir;
        crl_geom_e                 geom;
        logic [`CRL_COUNT_W-1:0]   count;
    } crl_instr_s;

endpackage : crl_pkg
